/* rtl/alt_lockout_trigger.sv */
// setup store, access-code lockout and rear trigger i/o
// How it works
// RL1 - store whole configuration into slot 1-9
// RL2 - recall whole configuration from slot 1-9
// RL3 - line frequency 50/60 Hz sets integration
// RL4 - lockout refuses protected settings and calibration; a slot recall still loads protected settings while locked
// RL5 - calibration needs unlocked and jumper present
// RL6 - escape then zero asks three-digit code
// RL7 - correct code, enter toggles, acknowledges, returns
// RL8 - escape at toggle prompt errors, unchanged
// RL9 - access code defaults to 555
// RL10 - zero at prompt changes code, escape keeps
// RL11 - code 999 only unlocks, never locks
// RL12 - temperature compensation always on
// RL13 - exactly one remote port, serial default
// RL14 - trigger source holds input low 10 ms
// RL15 - trigger sampled after each read cycle
// RL16 - done output idles high, pulses low 4.5 ms
// RL17 - one-shot modes measure once per trigger
// RL18 - wrong code leaves lockout, returns main
`timescale 1ns/10ps
`default_nettype none
module alt_lockout_trigger
  import alt_pkg::*;
#(
  parameter int DONE_CYC  = alt_pkg::DONE_PULSE_CYC,
  parameter int INTEG60   = alt_pkg::INTEG60_CYC,
  parameter int INTEG50   = alt_pkg::INTEG50_CYC
)
(
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire alt_pkg::alt_key_t key,
  input  wire logic              cfgWrValid,
  input  wire alt_pkg::alt_cfg_t cfgWrData,
  input  wire logic              storeReq,
  input  wire logic              recallReq,
  input  wire logic [3:0]        slotSel,
  input  wire logic              calReq,
  input  wire logic              calJumper,
  input  wire logic              trigInN,
  input  wire logic              measDone,
  output alt_pkg::alt_cfg_t      cfgOut,
  output logic                   cfgRefused,
  output logic                   lockOn,
  output alt_pkg::alt_msg_t      dispMsg,
  output logic [11:0]            dispCode,
  output logic [1:0]             digitCount,
  output logic                   calGrant,
  output logic                   calDeny,
  output logic [2:0]             commPortEn,
  output logic [INTEG_W-1:0]     integCycles,
  output logic                   tempCompEn,
  output logic                   measStart,
  output logic                   doneOutN
);
  import alt_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_ESC     = 7'h02,
    ST_ENTRY   = 7'h04,
    ST_TOGGLE  = 7'h08,
    ST_CHGASK  = 7'h10,
    ST_CHGEDIT = 7'h20,
    ST_CHGESC  = 7'h40
  } alt_state_t;

  function automatic logic isDigit(input logic [3:0] c);
    isDigit = (c <= KEY_NINE);
  endfunction

  function automatic logic slotOk(input logic [3:0] s);
    slotOk = (s >= SLOT_FIRST) && (s <= SLOT_LAST);
  endfunction

  function automatic logic commOk(input alt_comm_t m);
    commOk = (m == COMM_RS232) || (m == COMM_RS422) || (m == COMM_GPIB);
  endfunction

  alt_state_t  state_ff;
  alt_cfg_t    cfg_ff;
  alt_cfg_t    slots_ff [SLOT_COUNT];
  logic [11:0] pin_ff;
  logic [11:0] buf_ff;
  logic [1:0]  cnt_ff;
  logic        bypass_ff;
  logic [2:0]  calSync_ff;
  logic        calLvl_ff;
  logic [2:0]  trgSync_ff;
  logic        trgLvlN_ff;
  logic        busy_ff;
  logic        armed_ff;
  logic [3:0]  slotIdx;
  logic        digitKey;
  logic        oneShot;
  logic        sampleEn;

  assign slotIdx    = slotSel - SLOT_FIRST;
  assign digitKey   = key.valid && isDigit(key.code);
  assign oneShot    = cfg_ff.trigMode[0];
  assign cfgOut     = cfg_ff;
  assign dispCode   = buf_ff;
  assign digitCount = cnt_ff;
  assign tempCompEn = 1'b1; // RL12
  assign commPortEn = cfg_ff.commMode; // RL13
  assign integCycles = cfg_ff.lineFreq50 ? INTEG_W'(INTEG50) : INTEG_W'(INTEG60); // RL3

  // pin synchronisers; a level counts once the last two stages agree
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      calSync_ff <= 3'h0;
      calLvl_ff  <= 1'b0;
      trgSync_ff <= 3'h7;
      trgLvlN_ff <= 1'b1;
    end
    else
    begin
      calSync_ff <= {calSync_ff[1:0], calJumper};
      trgSync_ff <= {trgSync_ff[1:0], trigInN};
      if (calSync_ff[1] == calSync_ff[2])
        calLvl_ff <= calSync_ff[2];
      if (trgSync_ff[1] == trgSync_ff[2])
        trgLvlN_ff <= trgSync_ff[2];
    end
  end

  // configuration: writes, store and recall
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_ff     <= CFG_RESET;
      cfgRefused <= 1'b0;
      for (int i = 0; i < SLOT_COUNT; i++)
        slots_ff[i] <= CFG_RESET;
    end
    else
    begin
      cfgRefused <= 1'b0;
      if (storeReq && slotOk(slotSel))
        slots_ff[slotIdx] <= cfg_ff; // RL1
      if (recallReq && slotOk(slotSel))
        cfg_ff <= slots_ff[slotIdx]; // RL2
      else if (cfgWrValid)
      begin
        cfg_ff.busAddr  <= cfgWrData.busAddr;
        cfg_ff.compHigh <= cfgWrData.compHigh;
        cfg_ff.compLow  <= cfgWrData.compLow;
        cfg_ff.nominal  <= cfgWrData.nominal;
        if (lockOn)
        begin
          if ((cfgWrData.range != cfg_ff.range) || (cfgWrData.trigMode != cfg_ff.trigMode) ||
              (cfgWrData.delayMs != cfg_ff.delayMs) || (cfgWrData.commMode != cfg_ff.commMode) ||
              (cfgWrData.lineFreq50 != cfg_ff.lineFreq50))
            cfgRefused <= 1'b1; // RL4
        end
        else
        begin
          cfg_ff.range      <= cfgWrData.range;
          cfg_ff.trigMode   <= cfgWrData.trigMode;
          cfg_ff.delayMs    <= cfgWrData.delayMs;
          cfg_ff.lineFreq50 <= cfgWrData.lineFreq50; // RL3
          if (commOk(cfgWrData.commMode))
            cfg_ff.commMode <= cfgWrData.commMode; // RL13
        end
      end
    end
  end

  // calibration entry
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      calGrant <= 1'b0;
      calDeny  <= 1'b0;
    end
    else
    begin
      calGrant <= calReq && !lockOn && calLvl_ff; // RL5
      calDeny  <= calReq && (lockOn || !calLvl_ff); // RL4
    end
  end

  // front-panel access code menu
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff  <= ST_IDLE;
      lockOn    <= 1'b0;
      pin_ff    <= PIN_DEFAULT; // RL9
      buf_ff    <= 12'h000;
      cnt_ff    <= CNT_NONE;
      bypass_ff <= 1'b0;
      dispMsg   <= MSG_MAIN;
    end
    else if (key.valid)
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          dispMsg <= MSG_MAIN;
          if (key.code == KEY_ESC)
            state_ff <= ST_ESC;
        end
        ST_ESC:
        begin
          if (key.code == KEY_ZERO)
          begin
            state_ff <= ST_ENTRY; // RL6
            dispMsg  <= MSG_ASK_CODE;
            buf_ff   <= 12'h000;
            cnt_ff   <= CNT_NONE;
          end
          else
            state_ff <= (key.code == KEY_ESC) ? ST_ESC : ST_IDLE;
        end
        ST_ENTRY, ST_CHGEDIT:
        begin
          if (digitKey && (cnt_ff != PIN_DIGITS))
          begin
            buf_ff <= (cnt_ff == CNT_NONE) ? {8'h00, key.code} : {buf_ff[7:0], key.code};
            cnt_ff <= cnt_ff + CNT_ONE;
          end
          else if (key.code == KEY_ESC)
          begin
            if (cnt_ff != CNT_NONE)
            begin
              buf_ff <= {4'h0, buf_ff[11:4]}; // RL6
              cnt_ff <= cnt_ff - CNT_ONE;
            end
            else if (state_ff == ST_CHGEDIT)
              state_ff <= ST_CHGESC; // RL10
            else
            begin
              state_ff <= ST_IDLE;
              dispMsg  <= MSG_MAIN;
            end
          end
          else if ((key.code == KEY_ENTER) && (state_ff == ST_CHGEDIT))
          begin
            if (cnt_ff == PIN_DIGITS)
              pin_ff <= buf_ff; // RL10
            if ((cnt_ff == PIN_DIGITS) || (cnt_ff == CNT_NONE))
            begin
              state_ff <= ST_IDLE;
              dispMsg  <= MSG_ACK;
              cnt_ff   <= CNT_NONE;
            end
          end
          else if ((key.code == KEY_ENTER) && (cnt_ff == PIN_DIGITS))
          begin
            cnt_ff <= CNT_NONE;
            if (buf_ff == pin_ff)
            begin
              state_ff  <= ST_TOGGLE; // RL7
              bypass_ff <= 1'b0;
              dispMsg   <= MSG_ASK_TOGGLE;
            end
            else if ((buf_ff == PIN_BYPASS) && lockOn)
            begin
              state_ff  <= ST_TOGGLE; // RL11
              bypass_ff <= 1'b1;
              dispMsg   <= MSG_ASK_TOGGLE;
            end
            else
            begin
              state_ff <= ST_IDLE; // RL18
              dispMsg  <= MSG_MAIN;
            end
          end
        end
        ST_TOGGLE:
        begin
          if (key.code == KEY_ENTER)
          begin
            lockOn   <= bypass_ff ? 1'b0 : !lockOn; // RL7 RL11
            state_ff <= ST_IDLE;
            dispMsg  <= MSG_ACK;
          end
          else if (key.code == KEY_ESC)
          begin
            state_ff <= ST_IDLE; // RL8
            dispMsg  <= MSG_ERR;
          end
          else if ((key.code == KEY_ZERO) && !bypass_ff)
          begin
            state_ff <= ST_CHGASK; // RL10
            dispMsg  <= MSG_ASK_CHANGE;
          end
        end
        ST_CHGASK:
        begin
          if (key.code == KEY_ENTER)
          begin
            state_ff <= ST_CHGEDIT; // RL10
            dispMsg  <= MSG_SHOW_CODE;
            buf_ff   <= pin_ff;
            cnt_ff   <= CNT_NONE;
          end
          else if (key.code == KEY_ESC)
          begin
            state_ff <= ST_IDLE;
            dispMsg  <= MSG_ERR;
          end
        end
        ST_CHGESC:
        begin
          if (key.code == KEY_ENTER)
          begin
            state_ff <= ST_IDLE; // RL10
            dispMsg  <= MSG_MAIN;
          end
          else if (digitKey)
          begin
            state_ff <= ST_CHGEDIT;
            buf_ff   <= {8'h00, key.code};
            cnt_ff   <= CNT_ONE;
          end
        end
      endcase
    end
  end

  // trigger polling: after each read cycle, and continuously while idle in one-shot
  assign sampleEn = measDone || (oneShot && !busy_ff && !measStart); // RL15

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_ff   <= 1'b0;
      armed_ff  <= 1'b0;
      measStart <= 1'b0;
    end
    else
    begin
      measStart <= 1'b0;
      if (measStart)
        busy_ff <= 1'b1;
      else if (measDone)
        busy_ff <= 1'b0;
      if (sampleEn && oneShot)
      begin
        if (!trgLvlN_ff && armed_ff)
        begin
          measStart <= 1'b1; // RL17
          armed_ff  <= 1'b0;
        end
        else if (trgLvlN_ff)
          armed_ff <= 1'b1; // RL14
      end
      else if (!oneShot && (!busy_ff || measDone) && !measStart)
        measStart <= 1'b1;
    end
  end

  alt_done_pulse #(
    .PULSE_CYC (DONE_CYC)
  ) u_done (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .fire    (measDone),
    .doneN   (doneOutN)
  );
endmodule
`default_nettype wire

/* rtl/alt_pkg.sv */
// constants and types shared by the lockout, setup and trigger logic
package alt_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US     = 1000;
  localparam int NS_PER_S      = 1000000000;
  // done pulse nominal 4.5 ms, never below 4.25 ms
  localparam int DONE_PULSE_US  = 4500;
  localparam int DONE_PULSE_CYC = DONE_PULSE_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int DONE_CNT_W     = 20;
  // external trigger must stay low at least this long
  localparam int TRIG_MIN_MS = 10;
  localparam int LINE_HZ_60  = 60;
  localparam int LINE_HZ_50  = 50;
  localparam int INTEG60_CYC = NS_PER_S / (CLK_PERIOD_NS * LINE_HZ_60);
  localparam int INTEG50_CYC = NS_PER_S / (CLK_PERIOD_NS * LINE_HZ_50);
  localparam int INTEG_W     = 21;

  localparam logic [3:0]  KEY_ZERO    = 4'h0;
  localparam logic [3:0]  KEY_NINE    = 4'h9;
  localparam logic [3:0]  KEY_ENTER   = 4'ha;
  localparam logic [3:0]  KEY_ESC     = 4'hb;
  localparam logic [11:0] PIN_DEFAULT = 12'h555;
  localparam logic [11:0] PIN_BYPASS  = 12'h999;
  localparam logic [1:0]  PIN_DIGITS  = 2'h3;
  localparam logic [1:0]  CNT_NONE    = 2'h0;
  localparam logic [1:0]  CNT_ONE     = 2'h1;
  localparam logic [3:0]  SLOT_FIRST  = 4'h1;
  localparam logic [3:0]  SLOT_LAST   = 4'h9;
  localparam int          SLOT_COUNT  = 9;

  typedef enum logic [2:0] {
    COMM_RS232 = 3'h1,
    COMM_RS422 = 3'h2,
    COMM_GPIB  = 3'h4
  } alt_comm_t;

  typedef enum logic [1:0] {
    TRG_FAST_CONT = 2'h0,
    TRG_FAST_ONE  = 2'h1,
    TRG_DLY_CONT  = 2'h2,
    TRG_DLY_ONE   = 2'h3
  } alt_trig_t;

  typedef enum logic [6:0] {
    MSG_MAIN       = 7'h01,
    MSG_ASK_CODE   = 7'h02,
    MSG_ASK_TOGGLE = 7'h04,
    MSG_ACK        = 7'h08,
    MSG_ERR        = 7'h10,
    MSG_ASK_CHANGE = 7'h20,
    MSG_SHOW_CODE  = 7'h40
  } alt_msg_t;

  typedef struct packed {
    logic [4:0]  range;
    alt_trig_t   trigMode;
    logic [7:0]  delayMs;
    alt_comm_t   commMode;
    logic        lineFreq50;
    logic [4:0]  busAddr;
    logic [14:0] compHigh;
    logic [14:0] compLow;
    logic [14:0] nominal;
  } alt_cfg_t;

  localparam alt_cfg_t CFG_RESET = '{
    range:      5'h00,
    trigMode:   TRG_DLY_CONT,
    delayMs:    8'h6f,
    commMode:   COMM_RS232,
    lineFreq50: 1'b0,
    busAddr:    5'h01,
    compHigh:   15'h59d7,
    compLow:    15'h0000,
    nominal:    15'h0000
  };

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } alt_key_t;
endpackage

/* rtl/alt_done_pulse.sv */
// active-low reading-done pulse generator
`timescale 1ns/10ps
`default_nettype none
module alt_done_pulse
  import alt_pkg::*;
#(
  parameter int PULSE_CYC = alt_pkg::DONE_PULSE_CYC
)
(
  input  wire logic sys_clk,
  input  wire logic nrst,
  input  wire logic fire,
  output logic      doneN
);
  import alt_pkg::*;

  localparam logic [DONE_CNT_W-1:0] PULSE_LEN = DONE_CNT_W'(PULSE_CYC);
  localparam logic [DONE_CNT_W-1:0] CNT_ZERO  = '0;
  localparam logic [DONE_CNT_W-1:0] CNT_STEP  = DONE_CNT_W'(1);

  logic [DONE_CNT_W-1:0] remain_ff;

  // a new completion restarts the full low time
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      remain_ff <= CNT_ZERO;
      doneN     <= 1'b1;
    end
    else if (fire)
    begin
      remain_ff <= PULSE_LEN; // RL16
      doneN     <= 1'b0;
    end
    else if (remain_ff > CNT_STEP)
    begin
      remain_ff <= remain_ff - CNT_STEP;
    end
    else
    begin
      remain_ff <= CNT_ZERO;
      doneN     <= 1'b1; // RL16
    end
  end
endmodule
`default_nettype wire

/* testbench/alt_lockout_trigger_checker.sv */
// port assertions for the lockout and trigger block
`timescale 1ns/10ps
`default_nettype none
module alt_lockout_trigger_checker
  import alt_pkg::*;
#(
  parameter int DONE_CYC = 20
)
(
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire alt_pkg::alt_key_t key,
  input wire logic              cfgWrValid,
  input wire alt_pkg::alt_cfg_t cfgWrData,
  input wire logic              recallReq,
  input wire logic              calReq,
  input wire logic              measDone,
  input wire alt_pkg::alt_cfg_t cfgOut,
  input wire logic              cfgRefused,
  input wire logic              lockOn,
  input wire alt_pkg::alt_msg_t dispMsg,
  input wire logic              calGrant,
  input wire logic              calDeny,
  input wire logic [2:0]        commPortEn,
  input wire logic              tempCompEn,
  input wire logic              doneOutN
);
  import alt_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic [31:0] lowCnt;

  // length of the current low run, restarted by each completion
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      lowCnt <= 32'h0;
    else if (measDone)
      lowCnt <= 32'h0;
    else if (!doneOutN)
      lowCnt <= lowCnt + 32'h1;
  end

  property p_calLock;
    calReq && lockOn |=> calDeny && !calGrant;
  endproperty
  a_calLock: assert property (p_calLock) else $error("cal granted while locked");
  property p_calGrant;
    calGrant |-> !$past(lockOn);
  endproperty
  a_calGrant: assert property (p_calGrant) else $error("grant without unlock");
  property p_refuse;
    cfgWrValid && !recallReq && lockOn && cfgWrData.range != cfgOut.range |=> cfgRefused && $stable(cfgOut.range);
  endproperty
  a_refuse: assert property (p_refuse) else $error("locked range changed");
  property p_toggle;
    $changed(lockOn) |-> dispMsg == MSG_ACK;
  endproperty
  a_toggle: assert property (p_toggle) else $error("lock change without ack");
  property p_keyOnly;
    !key.valid |=> $stable(lockOn);
  endproperty
  a_keyOnly: assert property (p_keyOnly) else $error("lock changed without key");
  property p_comm;
    $onehot(commPortEn) && commPortEn == cfgOut.commMode;
  endproperty
  a_comm: assert property (p_comm) else $error("port enable not one-hot");
  property p_temp;
    tempCompEn;
  endproperty
  a_temp: assert property (p_temp) else $error("temp comp off");
  property p_doneLow;
    measDone |=> !doneOutN [*8];
  endproperty
  a_doneLow: assert property (p_doneLow) else $error("done pulse short");
  property p_doneCause;
    $fell(doneOutN) |-> $past(measDone);
  endproperty
  a_doneCause: assert property (p_doneCause) else $error("done pulse without cycle");
  property p_doneLen;
    $rose(doneOutN) |-> lowCnt == 32'(DONE_CYC);
  endproperty
  a_doneLen: assert property (p_doneLen) else $error("done pulse length wrong");
endmodule
bind alt_lockout_trigger alt_lockout_trigger_checker #(.DONE_CYC(DONE_CYC)) u_alt_lockout_trigger_checker (
  .sys_clk(sys_clk), .nrst(nrst), .key(key), .cfgWrValid(cfgWrValid), .cfgWrData(cfgWrData),
  .recallReq(recallReq), .calReq(calReq), .measDone(measDone), .cfgOut(cfgOut), .cfgRefused(cfgRefused),
  .lockOn(lockOn), .dispMsg(dispMsg), .calGrant(calGrant), .calDeny(calDeny), .commPortEn(commPortEn),
  .tempCompEn(tempCompEn), .doneOutN(doneOutN));
`default_nettype wire

/* testbench/alt_rear_partner.sv */
// trigger source and done-pulse watcher on the rear i/o
`timescale 1ns/10ps
`default_nettype none
module alt_rear_partner
(
  input  wire logic        sys_clk,
  input  wire logic        fire,
  input  wire logic [7:0]  holdCyc,
  input  wire logic        doneOutN,
  output logic             trigInN,
  output logic [31:0]      lowLen
);
  logic [7:0]  holdCnt = 8'h00;
  logic [31:0] runLen = 32'h0;
  initial trigInN = 1'b1;
  initial lowLen = 32'h0;
  // pulled-up line: low only while the hold count runs
  // fire is driven on the falling edge, so it is taken on the rising one
  always @(posedge sys_clk)
  begin
    if (fire)
      holdCnt <= holdCyc;
    else if (holdCnt != 8'h00)
      holdCnt <= holdCnt - 8'h01;
  end
  always @(negedge sys_clk) trigInN <= (holdCnt == 8'h00);
  always @(posedge sys_clk)
  begin
    if (doneOutN === 1'b0)
      runLen <= runLen + 32'h1;
    else if (runLen != 32'h0)
    begin
      lowLen <= runLen;
      runLen <= 32'h0;
    end
  end
endmodule
`default_nettype wire

/* testbench/alt_lockout_trigger_tb.sv */
// self-checking bench for the lockout and trigger block
`timescale 1ns/10ps
`default_nettype none
module alt_lockout_trigger_tb;
  import alt_pkg::*;
  localparam int DONE = 20;
  logic              sys_clk = 1'b0;
  logic              nrst = 1'b0;
  alt_key_t          key = '0;
  logic              cfgWrValid = 1'b0;
  alt_cfg_t          cfgWrData = CFG_RESET;
  logic              storeReq = 1'b0;
  logic              recallReq = 1'b0;
  logic [3:0]        slotSel = 4'h9;
  logic              calReq = 1'b0;
  logic              calJumper = 1'b0;
  logic              measDone = 1'b0;
  logic              fire = 1'b0;
  logic              trigInN;
  alt_cfg_t          cfgOut;
  logic              cfgRefused;
  logic              lockOn;
  alt_msg_t          dispMsg;
  logic [11:0]       dispCode;
  logic [1:0]        digitCount;
  logic              calGrant;
  logic              calDeny;
  logic [2:0]        commPortEn;
  logic [INTEG_W-1:0] integCycles;
  logic              tempCompEn;
  logic              measStart;
  logic              doneOutN;
  logic [31:0]       lowLen;
  alt_cfg_t          d;
  int                s0;
  int                miscompares = 0;
  int                n_checks = 0;
  int                cyc = 0;
  int                nStart = 0;

  alt_lockout_trigger #(.DONE_CYC(DONE), .INTEG60(60), .INTEG50(50)) u_alt_lockout_trigger (
    .sys_clk(sys_clk), .nrst(nrst), .key(key), .cfgWrValid(cfgWrValid), .cfgWrData(cfgWrData),
    .storeReq(storeReq), .recallReq(recallReq), .slotSel(slotSel), .calReq(calReq), .calJumper(calJumper),
    .trigInN(trigInN), .measDone(measDone), .cfgOut(cfgOut), .cfgRefused(cfgRefused), .lockOn(lockOn),
    .dispMsg(dispMsg), .dispCode(dispCode), .digitCount(digitCount), .calGrant(calGrant), .calDeny(calDeny),
    .commPortEn(commPortEn), .integCycles(integCycles), .tempCompEn(tempCompEn), .measStart(measStart),
    .doneOutN(doneOutN));
  alt_rear_partner u_alt_rear_partner (.sys_clk(sys_clk), .fire(fire), .holdCyc(8'h0c),
    .doneOutN(doneOutN), .trigInN(trigInN), .lowLen(lowLen));

  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (measStart === 1'b1)
      nStart++;
    if (cyc == 3000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [79:0] exp, input logic [79:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic kp(input logic [3:0] c);
    @(negedge sys_clk);
    key = '{1'b1, c};
    @(negedge sys_clk);
    key = '0;
  endtask
  task automatic pin(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
    kp(KEY_ESC);
    kp(KEY_ZERO);
    kp(a);
    kp(b);
    kp(c);
    kp(KEY_ENTER);
  endtask
  task automatic wr(input alt_cfg_t v);
    @(negedge sys_clk);
    cfgWrValid = 1'b1;
    cfgWrData = v;
    @(negedge sys_clk);
    cfgWrValid = 1'b0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic t_reset();
    chk("cfgOut", CFG_RESET, cfgOut);
    chk("lockOn", 0, lockOn);
    chk("commPortEn", 3'h1, commPortEn);
    chk("tempCompEn", 1, tempCompEn);
    chk("integCycles", 60, integCycles);
    chk("doneOutN", 1, doneOutN);
    $display("test reset done");
  endtask
  task automatic t_lock();
    kp(KEY_ESC);
    kp(KEY_ZERO);
    chk("dispMsg", MSG_ASK_CODE, dispMsg);
    kp(4'h5);
    kp(4'h5);
    kp(4'h4);
    kp(KEY_ESC);
    chk("dispCode", 12'h055, dispCode);
    chk("digitCount", 2'h2, digitCount);
    kp(4'h5);
    kp(KEY_ENTER);
    chk("dispMsg", MSG_ASK_TOGGLE, dispMsg);
    kp(KEY_ENTER);
    chk("lockOn", 1, lockOn);
    chk("dispMsg", MSG_ACK, dispMsg);
    $display("test lock done");
  endtask
  task automatic t_locked();
    d = CFG_RESET;
    d.range = 5'h03;
    d.lineFreq50 = 1'b1;
    d.busAddr = 5'h07;
    wr(d);
    chk("cfgRefused", 1, cfgRefused);
    chk("range", 5'h00, cfgOut.range);
    chk("busAddr", 5'h07, cfgOut.busAddr);
    chk("integCycles", 60, integCycles);
    @(negedge sys_clk);
    calReq = 1'b1;
    @(negedge sys_clk);
    calReq = 1'b0;
    chk("calDeny", 1, calDeny);
    $display("test locked done");
  endtask
  task automatic t_codes();
    pin(4'h1, 4'h2, 4'h3);
    chk("dispMsg", MSG_MAIN, dispMsg);
    chk("lockOn", 1, lockOn);
    pin(4'h5, 4'h5, 4'h5);
    kp(KEY_ESC);
    chk("dispMsg", MSG_ERR, dispMsg);
    chk("lockOn", 1, lockOn);
    pin(4'h9, 4'h9, 4'h9);
    kp(KEY_ENTER);
    chk("lockOn", 0, lockOn);
    pin(4'h9, 4'h9, 4'h9);
    chk("dispMsg", MSG_MAIN, dispMsg);
    $display("test codes done");
  endtask
  task automatic t_change();
    pin(4'h5, 4'h5, 4'h5);
    kp(KEY_ZERO);
    chk("dispMsg", MSG_ASK_CHANGE, dispMsg);
    kp(KEY_ENTER);
    chk("dispCode", 12'h555, dispCode);
    kp(4'h1);
    kp(4'h2);
    kp(4'h3);
    kp(KEY_ENTER);
    chk("dispMsg", MSG_ACK, dispMsg);
    pin(4'h5, 4'h5, 4'h5);
    chk("dispMsg", MSG_MAIN, dispMsg);
    pin(4'h1, 4'h2, 4'h3);
    kp(KEY_ZERO);
    kp(KEY_ENTER);
    kp(KEY_ESC);
    kp(KEY_ENTER);
    chk("dispMsg", MSG_MAIN, dispMsg);
    pin(4'h1, 4'h2, 4'h3);
    chk("dispMsg", MSG_ASK_TOGGLE, dispMsg);
    kp(KEY_ESC);
    $display("test change done");
  endtask
  task automatic t_cfg();
    d = CFG_RESET;
    d.lineFreq50 = 1'b1;
    d.commMode = COMM_GPIB;
    d.busAddr = 5'h1e;
    d.compHigh = 15'h0123;
    wr(d);
    chk("integCycles", 50, integCycles);
    chk("commPortEn", 3'h4, commPortEn);
    @(negedge sys_clk);
    storeReq = 1'b1;
    @(negedge sys_clk);
    storeReq = 1'b0;
    wr(CFG_RESET);
    chk("cfgOut", CFG_RESET, cfgOut);
    @(negedge sys_clk);
    recallReq = 1'b1;
    @(negedge sys_clk);
    recallReq = 1'b0;
    chk("cfgOut", d, cfgOut);
    d.commMode = alt_comm_t'(3'h3);
    wr(d);
    chk("commPortEn", 3'h4, commPortEn);
    calJumper = 1'b1;
    wait_n(6);
    calReq = 1'b1;
    @(negedge sys_clk);
    calReq = 1'b0;
    chk("calGrant", 1, calGrant);
    $display("test cfg done");
  endtask
  task automatic t_trig();
    d = CFG_RESET;
    d.trigMode = TRG_FAST_ONE;
    wr(d);
    @(negedge sys_clk);
    measDone = 1'b1;
    @(negedge sys_clk);
    measDone = 1'b0;
    chk("doneOutN", 0, doneOutN);
    s0 = nStart;
    wait_n(DONE + 4);
    chk("lowLen", DONE, lowLen);
    chk("starts", s0, nStart);
    fire = 1'b1;
    @(negedge sys_clk);
    fire = 1'b0;
    wait_n(25);
    chk("starts", s0 + 1, nStart);
    measDone = 1'b1;
    @(negedge sys_clk);
    measDone = 1'b0;
    fire = 1'b1;
    @(negedge sys_clk);
    fire = 1'b0;
    wait_n(25);
    chk("starts", s0 + 2, nStart);
    $display("test trig done");
  endtask

  initial
  begin
    wait_n(8);
    nrst = 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_lock();
    t_locked();
    t_codes();
    t_change();
    t_cfg();
    t_trig();
    conclude();
  end
endmodule
`default_nettype wire
